/* File: bench/piw_timer_chk.sv */
`timescale 1ns/1ps
module piw_timer_chk (
	input wire clk,
	input wire rstn,
	input wire [7:0] addr,
	input wire [7:0] wdata,
	input wire wr_stb,
	input wire rd_stb,
	input wire [7:0] rdata,
	input wire special_mode,
	input wire pll_supply_present,
	input wire periodic_irq,
	input wire monitor_active,
	input wire watchdog_reset,
	input wire monitor_reset
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// ****************************************
	// Shadow of the interrupt enable
	// ****************************************
	reg en_reg;
	wire wr_ctl = wr_stb && addr == 8'h16;
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			en_reg <= 1'b0;
		else if (wr_stb && addr == 8'h14)
			en_reg <= wdata[7];
	end
	a_irq_needs_enable: assert property (periodic_irq |-> $past(en_reg))
		else $error("request seen with enable clear");
	a_irq_drops_off: assert property (wr_stb && addr == 8'h14 && !wdata[7] |-> ##2 !periodic_irq)
		else $error("request stayed after enable cleared");
	a_rdata_idle_zero: assert property (!$past(rd_stb) |-> rdata == 8'h00)
		else $error("read data outside read slot");
	a_service_reads_zero: assert property (rd_stb && addr == 8'h17 |=> rdata == 8'h00)
		else $error("service register read not zero");
	a_monitor_strap: assert property ($rose(rstn) |-> ##3 monitor_active == pll_supply_present)
		else $error("monitor enable not loaded from supply strap");
	a_force_monitor_on: assert property (wr_ctl && special_mode && wdata[6] |-> ##2 monitor_active)
		else $error("forced monitor not active");
	a_force_both_reset: assert property (wr_ctl && special_mode && wdata[7:5] == 3'b101 && !wdata[3]
		&& wdata[2:0] != 3'b000 |-> ##[1:3] (watchdog_reset && monitor_reset))
		else $error("forced reset missing");
	a_disable_quiet: assert property (wr_ctl && special_mode && wdata[3]
		|-> ##2 (!watchdog_reset && !monitor_reset) [*4])
		else $error("reset raised while disabled");
	a_monitor_cause: assert property (monitor_reset |-> monitor_active || $past(monitor_active))
		else $error("monitor reset with monitor inactive");
	c_irq: cover property ($rose(periodic_irq));
	c_wd_reset: cover property ($rose(watchdog_reset));
	c_mon_reset: cover property ($rose(monitor_reset));
endmodule // piw_timer_chk

bind piw_timer piw_timer_chk u_chk (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
	.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .special_mode(special_mode),
	.pll_supply_present(pll_supply_present), .periodic_irq(periodic_irq),
	.monitor_active(monitor_active), .watchdog_reset(watchdog_reset),
	.monitor_reset(monitor_reset));

/* File: bench/piw_timer_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
	$display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module piw_timer_tb;
	reg clk = 1'b0;
	reg rstn = 1'b0;
	reg [7:0] addr = 8'h00;
	reg [7:0] wdata = 8'h00;
	reg wr_stb = 1'b0;
	reg rd_stb = 1'b0;
	reg special_mode = 1'b0;
	reg in_wait = 1'b0;
	reg in_debug = 1'b0;
	reg pll_supply_present = 1'b1;
	reg ref_clock_fail = 1'b0;
	wire [7:0] rdata;
	wire periodic_irq;
	wire monitor_active;
	wire watchdog_reset;
	wire monitor_reset;
	int fail_count = 0;
	int checked = 0;
	int test_no = 0;
	// A short prescaler keeps every watchdog period within 16384 cycles.
	piw_timer #(.PRESCALE_LOG2(4)) dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .special_mode(special_mode),
		.in_wait(in_wait), .in_debug(in_debug), .pll_supply_present(pll_supply_present),
		.ref_clock_fail(ref_clock_fail), .periodic_irq(periodic_irq),
		.monitor_active(monitor_active), .watchdog_reset(watchdog_reset),
		.monitor_reset(monitor_reset));
	initial forever #10 clk = ~clk;
	// ****************************************
	// Access tasks
	// ****************************************
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic rst(input bit sp, input bit pll);
		@(posedge clk);
		rstn <= 1'b0;
		special_mode <= sp;
		pll_supply_present <= pll;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		repeat (6) @(posedge clk);
		test_no++;
		$display("test %0d done", test_no);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		@(negedge clk);
		`CHK(rdata, e)
	endtask
	function automatic logic pick(input int w);
		case (w)
			0: pick = periodic_irq;
			1: pick = watchdog_reset;
			default: pick = monitor_reset;
		endcase
	endfunction
	task automatic await(input int w, input int n, input logic e);
		int i;
		for (i = 0; i < n && pick(w) !== e; i++)
			@(negedge clk);
		checked++;
		if (i >= n) begin
			fail_count++;
			$display("mismatch at %0t: wait ran out", $time);
			summarize();
		end
	endtask
	task automatic calm(input int w, input int n);
		repeat (n) begin
			@(negedge clk);
			`CHK(pick(w), 1'b0)
		end
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rst(1'b0, 1'b1);
		rd(8'h16, 8'h87);
		rd(8'h14, 8'h00);
		rd(8'h17, 8'h00);
		rd(8'h30, 8'h00);
		wr(8'h14, 8'hE9);
		rd(8'h14, 8'hE1);
		wr(8'h14, 8'h82);
		rd(8'h14, 8'hE2);
		await(0, 3000, 1'b1);
		wr(8'h14, 8'h62);
		await(0, 3, 1'b0);
		wr(8'h14, 8'hE2);
		await(0, 3, 1'b1);
		@(posedge clk);
		in_wait <= 1'b1;
		wr(8'h15, 8'h80);
		await(0, 3, 1'b0);
		calm(0, 400);
		@(posedge clk);
		in_wait <= 1'b0;
		await(0, 3000, 1'b1);
		@(posedge clk);
		in_debug <= 1'b1;
		wr(8'h15, 8'h80);
		await(0, 3, 1'b0);
		calm(0, 400);
		@(posedge clk);
		in_debug <= 1'b0;
		await(0, 3000, 1'b1);
		wr(8'h14, 8'hE0);
		wr(8'h15, 8'h80);
		await(0, 3, 1'b0);
		calm(0, 400);
		wr(8'h17, 8'h55);
		wr(8'h17, 8'h55);
		wr(8'h17, 8'hAA);
		calm(1, 4);
		wr(8'h17, 8'hAA);
		await(1, 3, 1'b1);
		rst(1'b0, 1'b1);
		wr(8'h17, 8'h12);
		await(1, 3, 1'b1);
		rst(1'b0, 1'b1);
		wr(8'h16, 8'h82);
		wr(8'h16, 8'h13);
		rd(8'h16, 8'h02);
		calm(1, 30);
		await(1, 200, 1'b1);
		rst(1'b1, 1'b1);
		rd(8'h16, 8'h8F);
		wr(8'h14, 8'h08);
		rd(8'h14, 8'h08);
		wr(8'h14, 8'h00);
		wr(8'h16, 8'h13);
		wr(8'h17, 8'h55);
		await(1, 3, 1'b1);
		rst(1'b1, 1'b1);
		wr(8'h16, 8'h13);
		repeat (220) @(posedge clk);
		wr(8'h17, 8'h55);
		wr(8'h17, 8'h55);
		wr(8'h17, 8'hAA);
		calm(1, 4);
		wr(8'h17, 8'h55);
		await(1, 3, 1'b1);
		rst(1'b1, 1'b1);
		wr(8'h16, 8'h2F);
		calm(1, 6);
		wr(8'h16, 8'hA7);
		await(2, 4, 1'b1);
		rst(1'b1, 1'b1);
		wr(8'h16, 8'h27);
		await(1, 4, 1'b1);
		`CHK(monitor_reset, 1'b0)
		rst(1'b1, 1'b1);
		wr(8'h16, 8'h07);
		@(posedge clk);
		ref_clock_fail <= 1'b1;
		calm(2, 6);
		wr(8'h16, 8'h47);
		await(2, 4, 1'b1);
		`CHK(monitor_active, 1'b1)
		@(posedge clk);
		ref_clock_fail <= 1'b0;
		rst(1'b1, 1'b0);
		rd(8'h16, 8'h0F);
		summarize();
	end
endmodule // piw_timer_tb

/* File: rtl/piw_regs.vh */
`ifndef PIW_REGS_VH
`define PIW_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define PIW_ADDR_W 8
`define PIW_OFF_CONTROL 8'h14
`define PIW_OFF_FLAG 8'h15
`define PIW_OFF_WDCTL 8'h16
`define PIW_OFF_SERVICE 8'h17

// ****************************************
// Field positions
// ****************************************
`define PIW_CTL_IRQ_EN 7
`define PIW_CTL_HALT_WAIT 6
`define PIW_CTL_HALT_DEBUG 5
`define PIW_CTL_BYPASS 3
`define PIW_FLG_TIMEOUT 7
`define PIW_WD_MON_EN 7
`define PIW_WD_FORCE_MON 6
`define PIW_WD_FORCE_RST 5
`define PIW_WD_WINDOW 4
`define PIW_WD_RST_DIS 3

// ****************************************
// Reset values and service codes
// ****************************************
`define PIW_CTL_RESET 8'h00
`define PIW_WD_RATE_RESET 3'h7
`define PIW_SERVICE_FIRST 8'h55
`define PIW_SERVICE_SECOND 8'hAA

// ****************************************
// Timing as log2 of module clock cycles, and the watchdog counter width
// ****************************************
`define PIW_PRESCALE_LOG2 13
`define PIW_BYPASS_LOG2 2
`define PIW_PERIODIC_BASE_LOG2 13
`define PIW_WD_CNT_W 23

`endif

/* File: rtl/piw_timer.v */
`timescale 1ns/1ps
`include "piw_regs.vh"
module piw_timer #(
	parameter PRESCALE_LOG2 = `PIW_PRESCALE_LOG2
) (
	clk,
	rstn,
	addr,
	wdata,
	wr_stb,
	rd_stb,
	rdata,
	special_mode,
	in_wait,
	in_debug,
	pll_supply_present,
	ref_clock_fail,
	periodic_irq,
	monitor_active,
	watchdog_reset,
	monitor_reset
);
	input wire clk;
	input wire rstn;
	input wire [`PIW_ADDR_W-1:0] addr;
	input wire [7:0] wdata;
	input wire wr_stb;
	input wire rd_stb;
	output reg [7:0] rdata;
	input wire special_mode;
	input wire in_wait;
	input wire in_debug;
	input wire pll_supply_present;
	input wire ref_clock_fail;
	output reg periodic_irq;
	output reg monitor_active;
	output reg watchdog_reset;
	output reg monitor_reset;

	// ****************************************
	// Helpers
	// ****************************************
	// Watchdog period as a power of two, zero meaning off.
	function [4:0] wd_log2;
		input [2:0] code;
		begin
			case (code)
				3'h1: wd_log2 = 5'd13;
				3'h2: wd_log2 = 5'd15;
				3'h3: wd_log2 = 5'd17;
				3'h4: wd_log2 = 5'd19;
				3'h5: wd_log2 = 5'd21;
				3'h6: wd_log2 = 5'd22;
				3'h7: wd_log2 = 5'd23;
				default: wd_log2 = 5'd0;
			endcase
		end
	endfunction

	// Last periodic count in prescale ticks; code n spans 2^(n-1) ticks.
	function [6:0] period_limit;
		input [2:0] code;
		begin
			case (code)
				3'h1: period_limit = 7'h00;
				3'h2: period_limit = 7'h01;
				3'h3: period_limit = 7'h03;
				3'h4: period_limit = 7'h07;
				3'h5: period_limit = 7'h0F;
				3'h6: period_limit = 7'h1F;
				3'h7: period_limit = 7'h3F;
				default: period_limit = 7'h00;
			endcase
		end
	endfunction

	// A strobe only counts for a register when the address matches exactly.
	function hit;
		input [`PIW_ADDR_W-1:0] a;
		input [`PIW_ADDR_W-1:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	// ****************************************
	// Registers
	// ****************************************
	reg irq_en_reg;
	reg halt_wait_reg;
	reg halt_debug_reg;
	reg bypass_reg;
	reg [2:0] prate_reg;
	reg flag_reg;
	reg mon_en_reg;
	reg force_mon_reg;
	reg force_rst_reg;
	reg window_reg;
	reg rst_dis_reg;
	reg [2:0] wrate_reg;
	reg once_ctl_reg;
	reg once_wd_reg;
	reg strap_done_reg;
	reg armed_reg;
	reg [PRESCALE_LOG2-1:0] pre_reg;
	reg [6:0] pcnt_reg;
	reg [`PIW_WD_CNT_W-1:0] wcnt_reg;

	wire halted = (halt_wait_reg & in_wait) | (halt_debug_reg & in_debug);
	wire wr_ctl = wr_stb & hit(addr, `PIW_OFF_CONTROL);
	wire wr_flg = wr_stb & hit(addr, `PIW_OFF_FLAG);
	wire wr_wd = wr_stb & hit(addr, `PIW_OFF_WDCTL);
	wire wr_svc = wr_stb & hit(addr, `PIW_OFF_SERVICE);
	// The once flags close on the first write of their register in normal modes,
	// whatever the value written, so a boot routine cannot retune the watchdog or the
	// halt controls later by accident. Special modes leave every control open for test.
	wire ctl_open = special_mode | ~once_ctl_reg;
	wire wd_open = special_mode | ~once_wd_reg;

	// ****************************************
	// Prescaler and periodic timer
	// ****************************************
	// The prescaler is shared and never cleared by a watchdog restart, so the
	// first watchdog tick after a service lands up to one prescale period early.
	wire pre_tick = ~halted & (bypass_reg ?
		(pre_reg[`PIW_BYPASS_LOG2-1:0] == {`PIW_BYPASS_LOG2{1'b1}}) :
		(&pre_reg));
	wire [6:0] plim = period_limit(prate_reg);
	wire p_expire = pre_tick & (prate_reg != 3'h0) & (pcnt_reg >= plim);

	// Halting freezes the prescaler itself, so a halted part resumes with the
	// same fraction of a tick still to run instead of losing it.
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			pre_reg <= {PRESCALE_LOG2{1'b0}};
		else if (!halted)
			pre_reg <= pre_reg + 1'b1;
	end

	// A rate of zero holds the count at zero, so switching the timer back on
	// starts a full count of ticks, the first of them landing up to one prescale period early.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pcnt_reg <= 7'h00;
		end else begin
			if (prate_reg == 3'h0)
				pcnt_reg <= 7'h00;
			else if (p_expire)
				pcnt_reg <= 7'h00;
			else if (pre_tick)
				pcnt_reg <= pcnt_reg + 7'h01;
		end
	end

	// ****************************************
	// Watchdog
	// ****************************************
	// The watchdog counts prescale ticks; cycles inside the first prescale
	// period are covered by the prescaler itself.
	wire [4:0] wl = wd_log2(wrate_reg);
	wire wd_on = (wl != 5'd0);
	wire [4:0] wshift = wl - 5'd13;
	wire [`PIW_WD_CNT_W-1:0] wticks = {{(`PIW_WD_CNT_W-1){1'b0}}, 1'b1} << wshift;
	wire [`PIW_WD_CNT_W-1:0] wopen = wticks - (wticks >> 2);
	// Greater-or-equal lets a change to a shorter period expire at the next prescale tick
	// instead of running on until the counter wraps.
	wire w_expire = wd_on & pre_tick & (wcnt_reg >= wticks - 1'b1);
	// At the fastest rate the open part of the period is empty, so every
	// service write in window mode counts as early there.
	wire in_window = (wcnt_reg >= wopen);

	// ****************************************
	// Service sequence checks
	// ****************************************
	// Every fault below is a single-cycle event taken from the write itself,
	// so a bad write is punished in the cycle after it and never deferred.
	wire svc_first = wr_svc & (wdata == `PIW_SERVICE_FIRST);
	wire svc_second = wr_svc & (wdata == `PIW_SERVICE_SECOND);
	wire svc_bad = wd_on & wr_svc & ~svc_first & ~svc_second;
	wire svc_early = wd_on & window_reg & wr_svc & ~in_window;
	wire svc_order = wd_on & svc_second & ~armed_reg;

	// ****************************************
	// Failure causes
	// ****************************************
	// A forced failure follows the watchdog rate and the monitor enable bit, not the
	// force-monitor bit; with both enabled both requests rise and the system picks the vector.
	// The monitor's own delay circuit lives outside; this block only turns
	// its fail level into a reset request.
	wire force_any = force_rst_reg & ~rst_dis_reg;
	wire mon_on = force_mon_reg | mon_en_reg;
	wire wd_fail = w_expire | svc_bad | svc_early | svc_order | (force_any & wd_on);
	wire mon_fail = (mon_on & ref_clock_fail) | (force_any & mon_en_reg);

	// Only a completed pair restarts the count; a lone second value is caught
	// as an ordering fault above.
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			wcnt_reg <= {`PIW_WD_CNT_W{1'b0}};
		else if (!wd_on || (svc_second && armed_reg) || w_expire)
			wcnt_reg <= {`PIW_WD_CNT_W{1'b0}};
		else if (pre_tick)
			wcnt_reg <= wcnt_reg + 1'b1;
	end

	// The first value may be repeated; the arm drops with the second value
	// and whenever the watchdog is off.
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			armed_reg <= 1'b0;
		else if (!wd_on || (svc_second && armed_reg))
			armed_reg <= 1'b0;
		else if (svc_first)
			armed_reg <= 1'b1;
	end

	// ****************************************
	// Strap capture and monitor enable
	// ****************************************
	// The supply strap is a live pin, so it is caught on the first clock after
	// release rather than in the reset branch; a write in that cycle is dropped.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			strap_done_reg <= 1'b0;
			mon_en_reg <= 1'b0;
		end else if (!strap_done_reg) begin
			strap_done_reg <= 1'b1;
			mon_en_reg <= pll_supply_present;
		end else if (wr_wd) begin
			mon_en_reg <= wdata[`PIW_WD_MON_EN];
		end
	end

	// ****************************************
	// Periodic control register
	// ****************************************
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_en_reg <= 1'b0;
			halt_wait_reg <= 1'b0;
			halt_debug_reg <= 1'b0;
			bypass_reg <= 1'b0;
			prate_reg <= 3'h0;
			once_ctl_reg <= 1'b0;
		end else if (wr_ctl) begin
			irq_en_reg <= wdata[`PIW_CTL_IRQ_EN];
			prate_reg <= wdata[2:0];
			once_ctl_reg <= 1'b1;
			if (ctl_open) begin
				halt_wait_reg <= wdata[`PIW_CTL_HALT_WAIT];
				halt_debug_reg <= wdata[`PIW_CTL_HALT_DEBUG];
			end
			// Bypass only shortens the prescaler for test; a stray write in a
			// normal mode would speed up both timers, so it is shut there.
			if (special_mode)
				bypass_reg <= wdata[`PIW_CTL_BYPASS];
		end
	end

	// ****************************************
	// Watchdog and monitor control register
	// ****************************************
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			force_mon_reg <= 1'b0;
			force_rst_reg <= 1'b0;
			window_reg <= 1'b0;
			rst_dis_reg <= 1'b0;
			wrate_reg <= `PIW_WD_RATE_RESET;
			once_wd_reg <= 1'b0;
		end else if (!strap_done_reg) begin
			// Reset generation starts disabled in special modes.
			rst_dis_reg <= special_mode;
		end else if (wr_wd) begin
			once_wd_reg <= 1'b1;
			if (wd_open) begin
				force_mon_reg <= wdata[`PIW_WD_FORCE_MON];
				window_reg <= wdata[`PIW_WD_WINDOW];
				wrate_reg <= wdata[2:0];
			end
			if (special_mode) begin
				force_rst_reg <= wdata[`PIW_WD_FORCE_RST];
				rst_dis_reg <= wdata[`PIW_WD_RST_DIS];
			end
		end
	end

	// ****************************************
	// Periodic time-out flag
	// ****************************************
	// A new time-out beats a clear in the same cycle, so no period is lost.
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			flag_reg <= 1'b0;
		else if (p_expire)
			flag_reg <= 1'b1;
		else if (wr_flg && wdata[`PIW_FLG_TIMEOUT])
			flag_reg <= 1'b0;
	end

	// ****************************************
	// Interrupt and monitor status
	// ****************************************
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			periodic_irq <= 1'b0;
			monitor_active <= 1'b0;
		end else begin
			periodic_irq <= flag_reg & irq_en_reg;
			monitor_active <= mon_on;
		end
	end

	// ****************************************
	// Reset requests
	// ****************************************
	// Requests are levels that stand as long as their cause does; the system
	// reset they trigger is expected to clear this block as well.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			watchdog_reset <= 1'b0;
			monitor_reset <= 1'b0;
		end else begin
			watchdog_reset <= wd_fail & ~rst_dis_reg;
			monitor_reset <= mon_fail & ~rst_dis_reg;
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	wire [7:0] ctl_image = {irq_en_reg, halt_wait_reg, halt_debug_reg, 1'b0, bypass_reg,
		prate_reg};
	wire [7:0] flg_image = {flag_reg, 7'h00};
	wire [7:0] wd_image = {mon_en_reg, force_mon_reg, force_rst_reg, window_reg,
		rst_dis_reg, wrate_reg};

	// Read data stand only in the cycle after the strobe and are zero otherwise,
	// so a stale value can never be taken for a fresh one.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= 8'h00;
		end else if (rd_stb) begin
			case (addr)
				`PIW_OFF_CONTROL: rdata <= ctl_image;
				`PIW_OFF_FLAG: rdata <= flg_image;
				`PIW_OFF_WDCTL: rdata <= wd_image;
				default: rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end
endmodule // piw_timer
